// [include/eewp_pkg.sv]
// Purpose: Shared constants and types for the two-wire EEPROM slave.
// Assumes: Core clock of 20 MHz; link sampling clock supplied separately.
// Notes: Timing counts are derived from the printed times.
package eewp_pkg;
    localparam int unsigned EEWP_CLK_HZ = 32'h0131_2D00;
    localparam int unsigned EEWP_MS_PER_S = 32'h0000_03E8;
    localparam int unsigned EEWP_TWR_MS = 32'h0000_000A;
    localparam int unsigned EEWP_TWR_CYCLES =
        EEWP_TWR_MS * (EEWP_CLK_HZ / EEWP_MS_PER_S);
    localparam int unsigned EEWP_ADDR_W = 32'h0000_0007;
    localparam int unsigned EEWP_PAGE_BITS = 32'h0000_0003;
    localparam logic [6:0] EEWP_DEV_ADDR = 7'h50;
    localparam logic [6:0] EEWP_FUSE_ADDR = 7'h7F;
    localparam logic [3:0] EEWP_BITS_BYTE = 4'h8;
    localparam logic [3:0] EEWP_BIT_LAST = 4'h7;
    localparam logic EEWP_RW_READ = 1'h1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_RACK
    } eewp_state_e;

    typedef enum logic [1:0] {
        RL_CTRL,
        RL_WADDR,
        RL_DATA,
        RL_READ
    } eewp_role_e;

    typedef struct packed {
        logic scl;
        logic sda;
        logic stream;
        logic wp_n;
    } eewp_pins_s;

    localparam eewp_pins_s EEWP_PINS_IDLE = 4'hF;
endpackage

// [rtl/eewp_slave.sv]
// Purpose: Two-wire slave with page buffer, self-timed write and protection.
// Assumes: Pins are sampled on i_link_clk; write timer runs on i_clk.
// Notes: The array is held in the link domain and is not reset.
//
// Overview of operation
// - SDA fall with SCL high is Start.
// - SDA rise with SCL high is Stop.
// - SDA changes only while SCL low.
// - Only the last eight bytes are kept.
// - Bidirectional mode stays until power removal.
// - Every received byte of an addressed transfer gets acknowledged unless a write cycle is pending.
// - No acknowledge during the programming cycle.
// - Acknowledge holds SDA low through SCL high.
// - Release SDA when master withholds acknowledge.
// - Control byte is address plus direction.
// - Acknowledge only matching address when idle.
// - Word address loads the address pointer.
// - Stop after write starts programming.
// - Stream clock pin high during transfer.
// - Page buffer commits only at Stop.
// - Only three low pointer bits increment on writes; reads step the whole pointer.
// - Stream clock pin low blocks all writes.
// - Writing last location sets protect fuse.
// - Fuse set plus protect low blocks writes.
// - Reads support current, random and sequential.
// - Address counter advances after each access.
// - Acknowledged read byte sends next byte.
// - Protect pin is active low.
`timescale 1ns/1ps
`default_nettype none
module eewp_slave #(
    parameter int unsigned P_TWR_CYCLES = eewp_pkg::EEWP_TWR_CYCLES,
    parameter int unsigned P_ADDR_W = eewp_pkg::EEWP_ADDR_W,
    parameter int unsigned P_PAGE_BITS = eewp_pkg::EEWP_PAGE_BITS
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_link_clk,
    input wire eewp_pkg::eewp_pins_s i_pins,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_bidir_mode,
    output logic o_fuse_set,
    output logic o_write_busy
);
    import eewp_pkg::*;

    localparam int unsigned DEPTH = 1 << P_ADDR_W;
    localparam int unsigned PAGE = 1 << P_PAGE_BITS;
    localparam int unsigned CNT_W = $clog2(P_TWR_CYCLES + 1);
    localparam logic [CNT_W-1:0] TWR_LOAD = CNT_W'(P_TWR_CYCLES);
    // Bit positions inside a serial byte.
    localparam int unsigned BYTE_MSB = EEWP_BIT_LAST;
    localparam int unsigned NEXT_MSB = BYTE_MSB - 1;
    localparam int unsigned RW_POS = 0;
    localparam int unsigned ADDR_LSB = RW_POS + 1;

    // Link domain: pin synchronisers and edge history.
    eewp_pins_s sync_a;
    eewp_pins_s sync_b;
    logic scl_q;
    logic sda_q;

    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_a <= EEWP_PINS_IDLE;
            sync_b <= EEWP_PINS_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            sync_a <= i_pins;
            sync_b <= sync_a;
            scl_q <= sync_b.scl;
            sda_q <= sync_b.sda;
        end
    end

    wire scl_rise = sync_b.scl & ~scl_q;
    wire scl_fall = ~sync_b.scl & scl_q;
    // A Start is only seen from a high line, so transfers need an idle bus.
    wire bus_start = sync_b.scl & scl_q & sda_q & ~sync_b.sda;
    wire bus_stop = sync_b.scl & scl_q & ~sda_q & sync_b.sda;

    // Link domain state.
    eewp_state_e state;
    eewp_role_e role;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx_sh;
    logic [P_ADDR_W-1:0] ptr;
    logic rack_ok;
    logic stream_ok;
    logic pend;
    logic busy_seen;
    logic commit_tgl;
    logic busy_a;
    logic busy_b;
    logic [PAGE-1:0] valid;
    logic [PAGE-1:0][7:0] page_buf;
    logic [7:0] mem [DEPTH];

    // Decodes shared by the framing, buffer and gating logic.
    wire in_rx = (state == ST_RX);
    wire in_rack = (state == ST_RACK);
    wire role_read = (role == RL_READ);
    wire role_data = (role == RL_DATA);
    wire ctrl_is_read = (sh[RW_POS] == EEWP_RW_READ);
    wire tx_last = (cnt == EEWP_BIT_LAST);

    wire [P_PAGE_BITS-1:0] ptr_lo = ptr[P_PAGE_BITS-1:0];
    wire [P_ADDR_W-P_PAGE_BITS-1:0] ptr_hi = ptr[P_ADDR_W-1:P_PAGE_BITS];
    wire [7:0] rd_byte = mem[ptr];
    wire tx_first_bit = rd_byte[BYTE_MSB];
    wire byte_end = in_rx & scl_fall & (cnt == EEWP_BITS_BYTE);
    wire addr_match = (sh[BYTE_MSB:ADDR_LSB] == EEWP_DEV_ADDR);
    wire ctrl_ack = addr_match & ~pend & o_bidir_mode;
    wire byte_ack = (role == RL_CTRL) ? ctrl_ack : ~pend;
    wire data_take = byte_end & role_data;
    wire prot_on = o_fuse_set & ~sync_b.wp_n;
    wire wr_allow = stream_ok & sync_b.stream & ~prot_on;
    wire commit = bus_stop & (role == RL_DATA) & (|valid)
        & wr_allow & ~pend;
    wire fuse_hit = commit & valid[EEWP_FUSE_ADDR[P_PAGE_BITS-1:0]]
        & (ptr_hi == EEWP_FUSE_ADDR[P_ADDR_W-1:P_PAGE_BITS]);
    wire [P_ADDR_W-1:0] next_ptr_page =
        {ptr_hi, P_PAGE_BITS'(ptr_lo + 1'b1)};
    wire [P_ADDR_W-1:0] next_ptr_seq = ptr + 1'b1;

    // Mode flag: the first SCL fall enters bidirectional mode for good.
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bidir_mode <= 1'b0;
        end else if (scl_fall) begin
            o_bidir_mode <= 1'b1;
        end
    end

    // Serial framing, acknowledge and transmit engine.
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            role <= RL_CTRL;
            cnt <= '0;
            sh <= '0;
            tx_sh <= '0;
            ptr <= '0;
            o_sda_oe <= 1'b0;
        end else if (bus_start) begin
            state <= ST_RX;
            role <= RL_CTRL;
            cnt <= '0;
            o_sda_oe <= 1'b0;
        end else if (bus_stop) begin
            state <= ST_IDLE;
            o_sda_oe <= 1'b0;
        end else begin
            case (state)
                ST_RX: begin
                    if (scl_rise) begin
                        sh <= {sh[NEXT_MSB:0], sync_b.sda};
                        cnt <= cnt + 1'b1;
                    end else if (byte_end) begin
                        state <= ST_ACK;
                        cnt <= '0;
                        o_sda_oe <= byte_ack;
                        case (role)
                            RL_CTRL: begin
                                role <= ctrl_is_read ?
                                    RL_READ : RL_WADDR;
                            end
                            RL_WADDR: begin
                                ptr <= sh[P_ADDR_W-1:0];
                                role <= RL_DATA;
                            end
                            RL_DATA: begin
                                ptr <= next_ptr_page;
                            end
                            default: begin
                                role <= role;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (!o_sda_oe) begin
                            state <= ST_IDLE;
                        end else if (role_read) begin
                            state <= ST_TX;
                            tx_sh <= rd_byte;
                            o_sda_oe <= ~tx_first_bit;
                            ptr <= next_ptr_seq;
                        end else begin
                            state <= ST_RX;
                            o_sda_oe <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (tx_last) begin
                            state <= ST_RACK;
                            cnt <= '0;
                            o_sda_oe <= 1'b0;
                        end else begin
                            tx_sh <= {tx_sh[NEXT_MSB:0], 1'b0};
                            o_sda_oe <= ~tx_sh[NEXT_MSB];
                            cnt <= cnt + 1'b1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_fall) begin
                        if (rack_ok) begin
                            state <= ST_TX;
                            tx_sh <= rd_byte;
                            o_sda_oe <= ~tx_first_bit;
                            ptr <= next_ptr_seq;
                        end else begin
                            state <= ST_IDLE;
                            o_sda_oe <= 1'b0;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Master acknowledge after each sent byte, taken at the SCL rise.
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rack_ok <= 1'b0;
        end else if (in_rack && scl_rise) begin
            rack_ok <= ~sync_b.sda;
        end
    end

    // Page buffer: each entry overwrites the oldest with the same slot.
    for (genvar g = 0; g < PAGE; g++) begin : g_buf
        wire hit = data_take & (ptr_lo == P_PAGE_BITS'(g));
        always_ff @(posedge i_link_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                valid[g] <= 1'b0;
            end else if (bus_start) begin
                valid[g] <= 1'b0;
            end else if (hit) begin
                valid[g] <= 1'b1;
            end
        end
        always_ff @(posedge i_link_clk) begin
            if (hit) begin
                page_buf[g] <= sh;
            end
        end
    end

    // Array update at the Stop that closes a permitted write.
    always_ff @(posedge i_link_clk) begin
        if (commit) begin
            for (int k = 0; k < PAGE; k++) begin
                if (valid[k]) begin
                    mem[{ptr_hi, P_PAGE_BITS'(k)}] <= page_buf[k];
                end
            end
        end
    end

    // Write gating: stream pin must stay high from Start to Stop.
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stream_ok <= 1'b1;
        end else if (bus_start) begin
            stream_ok <= sync_b.stream;
        end else if (state != ST_IDLE && !sync_b.stream) begin
            stream_ok <= 1'b0;
        end
    end

    // Protect fuse: set once by a commit that covers the last location.
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fuse_set <= 1'b0;
        end else if (fuse_hit) begin
            o_fuse_set <= 1'b1;
        end
    end

    // Busy flag brought back into the link domain through two flops.
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_a <= 1'b0;
            busy_b <= 1'b0;
        end else begin
            busy_a <= o_write_busy;
            busy_b <= busy_a;
        end
    end

    // Busy tracking in the link domain until the core timer has finished.
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            commit_tgl <= 1'b0;
            pend <= 1'b0;
            busy_seen <= 1'b0;
        end else begin
            if (commit) begin
                commit_tgl <= ~commit_tgl;
                pend <= 1'b1;
                busy_seen <= 1'b0;
            end else if (pend && busy_b) begin
                busy_seen <= 1'b1;
            end else if (pend && busy_seen && !busy_b) begin
                pend <= 1'b0;
                busy_seen <= 1'b0;
            end
        end
    end

    // Core domain: self-timed write cycle, blind to the stream pin.
    logic cmt_a;
    logic cmt_b;
    logic cmt_q;
    logic [CNT_W-1:0] twr_cnt;

    wire cmt_pulse = cmt_b ^ cmt_q;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cmt_a <= 1'b0;
            cmt_b <= 1'b0;
            cmt_q <= 1'b0;
        end else begin
            cmt_a <= commit_tgl;
            cmt_b <= cmt_a;
            cmt_q <= cmt_b;
        end
    end

    // Write timer: busy stands for the loaded count plus one cycle.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            twr_cnt <= '0;
            o_write_busy <= 1'b0;
        end else begin
            if (cmt_pulse) begin
                twr_cnt <= TWR_LOAD;
                o_write_busy <= 1'b1;
            end else if (twr_cnt != '0) begin
                twr_cnt <= twr_cnt - 1'b1;
            end else begin
                o_write_busy <= 1'b0;
            end
        end
    end

    // The pin output level is always low; only the enable moves.
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sda_out <= 1'b0;
        end else begin
            o_sda_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [sim/eewp_checker.sv]
// Purpose: Port-level assertions for the two-wire EEPROM slave.
// Assumes: i_pins carries raw pin levels with SDA as the resolved wire.
// Notes: Bound to every instance of the slave.
`timescale 1ns/1ps
`default_nettype none
module eewp_checker #(
    parameter int unsigned P_TWR_CYCLES = eewp_pkg::EEWP_TWR_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_link_clk,
    input wire eewp_pkg::eewp_pins_s i_pins,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic o_bidir_mode,
    input wire logic o_fuse_set,
    input wire logic o_write_busy
);
    import eewp_pkg::*;
    logic [31:0] busy_cnt;
    logic [31:0] next_busy_cnt;
    assign next_busy_cnt = o_write_busy ? busy_cnt + 32'h0000_0001 : '0;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_cnt <= '0;
        end else begin
            busy_cnt <= next_busy_cnt;
        end
    end
    sequence start_s;
        i_pins.scl && $fell(i_pins.sda);
    endsequence
    sequence stop_s;
        i_pins.scl && $rose(i_pins.sda);
    endsequence
    sequence busy_seen_s;
        o_write_busy [*6];
    endsequence
    sequence ack_high_s;
        o_sda_oe && i_pins.scl;
    endsequence
    bidir_keep_a: assert property (@(posedge i_link_clk)
        disable iff (!i_rst_n) o_bidir_mode |=> o_bidir_mode)
        else $error("bidirectional mode dropped");
    fuse_keep_a: assert property (@(posedge i_link_clk)
        disable iff (!i_rst_n) o_fuse_set |=> o_fuse_set)
        else $error("protect fuse cleared");
    fuse_busy_a: assert property (@(posedge i_link_clk)
        disable iff (!i_rst_n) $rose(o_fuse_set) |-> ##[0:10] o_write_busy)
        else $error("fuse set without a write cycle");
    busy_len_a: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        $fell(o_write_busy) |-> busy_cnt == P_TWR_CYCLES + 32'h0000_0001)
        else $error("write cycle length wrong");
    busy_noack_a: assert property (@(posedge i_link_clk)
        disable iff (!i_rst_n) busy_seen_s |-> !$rose(o_sda_oe))
        else $error("drive started during write cycle");
    oe_change_a: assert property (@(posedge i_link_clk)
        disable iff (!i_rst_n) $changed(o_sda_oe) |-> !i_pins.scl)
        else $error("data drive changed while clock high");
    ack_hold_a: assert property (@(posedge i_link_clk)
        disable iff (!i_rst_n) ack_high_s |=> o_sda_oe || !i_pins.scl)
        else $error("drive dropped during clock high");
    cond_release_a: assert property (@(posedge i_link_clk)
        disable iff (!i_rst_n) (start_s or stop_s) |-> ##[0:6] !o_sda_oe)
        else $error("line held after start or stop");
endmodule
bind eewp_slave eewp_checker #(.P_TWR_CYCLES(P_TWR_CYCLES)) u_chk (
    .i_clk, .i_rst_n, .i_link_clk, .i_pins, .o_sda_out, .o_sda_oe,
    .o_bidir_mode, .o_fuse_set, .o_write_busy
);
`default_nettype wire

// [sim/eewp_master.sv]
// Purpose: Behavioural two-wire bus master that drives the serial clock.
// Assumes: SDA is open drain with a pull-up; each phase is 8 core clocks.
// Notes: Reports every byte with its ninth bit on o_got and o_rx.
`timescale 1ns/1ps
`default_nettype none
module eewp_master (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low,
    output logic o_got,
    output logic [8:0] o_rx
);
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
        o_got = 1'b0;
        o_rx = '0;
    end
    task automatic half();
        repeat (8) @(posedge i_clk);
        #1;
    endtask
    task automatic start();
        o_sda_low = 1'b0;
        half();
        o_scl = 1'b1;
        half();
        o_sda_low = 1'b1;
        half();
        o_scl = 1'b0;
    endtask
    task automatic stop();
        o_sda_low = 1'b1;
        half();
        o_scl = 1'b1;
        half();
        o_sda_low = 1'b0;
        half();
    endtask
    task automatic bit_x(input logic b, output logic r);
        o_sda_low = !b;
        half();
        o_scl = 1'b1;
        half();
        r = i_sda;
        o_scl = 1'b0;
    endtask
    task automatic byte_x(input logic [7:0] d, input logic ack);
        logic [8:0] r;
        for (int i = 8; i >= 0; i--) begin
            bit_x(i > 0 ? d[i-1] : !ack, r[i]);
        end
        o_rx = r;
        o_got = 1'b1;
        @(posedge i_clk);
        #1;
        o_got = 1'b0;
    endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Purpose: Self-checking bench for the two-wire EEPROM slave.
// Assumes: The master model drives SCL; SDA has a pull-up.
// Notes: The write cycle is shortened to 600 core clocks.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import eewp_pkg::*;
    localparam int unsigned TWR = 32'h0000_0258;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst_n = 1'b0;
    logic stream = 1'b1;
    logic wp_n = 1'b1;
    logic scl, m_low, got, oe, sda_out, bidir, fuse, busy;
    logic [8:0] rx;
    logic [8:0] expq [$];
    logic [7:0] mem [128];
    int n_fail = 0;
    int checks_done = 0;
    wire logic sda;
    eewp_pins_s pins;
    assign sda = !(m_low || (oe && !sda_out));
    assign pins = {scl, sda, stream, wp_n};
    always #25 clk = !clk;
    always #24 lclk = !lclk;
    eewp_slave #(.P_TWR_CYCLES(TWR)) dut (
        .i_clk(clk), .i_rst_n(rst_n), .i_link_clk(lclk), .i_pins(pins),
        .o_sda_out(sda_out), .o_sda_oe(oe), .o_bidir_mode(bidir),
        .o_fuse_set(fuse), .o_write_busy(busy)
    );
    eewp_master m (
        .i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low),
        .o_got(got), .o_rx(rx)
    );
    task automatic check(input string s, input logic [8:0] v, e);
        checks_done++;
        if (v !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", s, e, v);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] d, input logic ok);
        expq.push_back({d, !ok});
        m.byte_x(d, 1'b0);
    endtask
    task automatic rd(input logic [7:0] d, input logic mack);
        expq.push_back({d, !mack});
        m.byte_x(8'hFF, mack);
    endtask
    task automatic bw(input logic [7:0] a, input logic [7:0] d);
        m.start();
        wr(8'hA0, 1'b1);
        wr(a, 1'b1);
        wr(d, 1'b1);
        m.stop();
    endtask
    task automatic rr(input logic [7:0] a, input int n);
        m.start();
        wr(8'hA0, 1'b1);
        wr(a, 1'b1);
        m.start();
        wr(8'hA1, 1'b1);
        for (int i = 0; i < n; i++) begin
            rd(mem[7'(a + i)], i < n - 1);
        end
        m.stop();
    endtask
    task automatic wb(input logic v, input int lim, input logic e);
        int k;
        k = 0;
        while (busy !== v && k < lim) begin
            @(posedge clk);
            #1;
            k++;
        end
        check("write busy", busy, e);
        repeat (4) @(posedge lclk);
        #1;
    endtask
    always @(posedge clk) begin
        if (got === 1'b1) begin
            check("bus byte", rx, expq.pop_front());
        end
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        test_done();
    end
    initial begin
        int a;
        logic [7:0] d;
        void'($urandom(14104));
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (6) @(posedge lclk);
        #1;
        check("mode at rest", bidir, 1'b0);
        check("fuse at rest", fuse, 1'b0);
        a = $urandom_range(32'h0000_007F, 32'h0000_0051);
        m.start();
        wr({a[6:0], 1'b0}, 1'b0);
        m.stop();
        check("mode after clock", bidir, 1'b1);
        $display("test address done");
        m.start();
        wr(8'hA0, 1'b1);
        wr(8'h88, 1'b1);
        for (int i = 0; i < 10; i++) begin
            d = 8'($urandom);
            mem[8 + i % 8] = d;
            wr(d, 1'b1);
        end
        m.stop();
        wb(1'b1, 20, 1'b1);
        m.start();
        wr(8'hA0, 1'b0);
        m.stop();
        wb(1'b0, 1000, 1'b0);
        m.start();
        wr(8'hA0, 1'b1);
        rr(8'h88, 4);
        m.start();
        wr(8'hA1, 1'b1);
        rd(mem[12], 1'b0);
        m.stop();
        $display("test page done");
        d = 8'($urandom);
        mem[32] = d;
        bw(8'h20, d);
        wb(1'b1, 20, 1'b1);
        stream = 1'b0;
        wb(1'b0, 1000, 1'b0);
        bw(8'h20, ~d);
        wb(1'b1, 20, 1'b0);
        stream = 1'b1;
        rr(8'h20, 1);
        $display("test stream done");
        mem[127] = d;
        bw(8'h7F, d);
        wb(1'b1, 20, 1'b1);
        check("fuse after write", fuse, 1'b1);
        wb(1'b0, 1000, 1'b0);
        wp_n = 1'b0;
        bw(8'h30, d);
        wb(1'b1, 20, 1'b0);
        wp_n = 1'b1;
        mem[48] = ~d;
        bw(8'h30, ~d);
        wb(1'b1, 20, 1'b1);
        wb(1'b0, 1000, 1'b0);
        rr(8'h7F, 1);
        rr(8'h30, 1);
        $display("test protect done");
        check("left over", 9'(expq.size()), 9'h000);
        test_done();
    end
endmodule
`default_nettype wire
